// file: hdl/dmam_pkg.sv
// dmam_pkg: constants for the default memory attribute map and barrier unit
// assumes a 32-bit byte address space and a core that issues barriers as pulses
package dmam_pkg;
	// memory types
	typedef enum logic [1:0] {
		DMAM_NORMAL   = 2'h0,
		DMAM_DEVICE   = 2'h1,
		DMAM_STRONG   = 2'h3,
		DMAM_RESERVED = 2'h2
	} dmam_mem_type;

	// region bounds (inclusive)
	localparam logic [31:0] CODE_LO  = 32'h00000000;
	localparam logic [31:0] CODE_HI  = 32'h1FFFFFFF;
	localparam logic [31:0] SRAM_LO  = 32'h20000000;
	localparam logic [31:0] SRAM_HI  = 32'h3FFFFFFF;
	localparam logic [31:0] PERI_LO  = 32'h40000000;
	localparam logic [31:0] PERI_HI  = 32'h5FFFFFFF;
	localparam logic [31:0] XRAM_LO  = 32'h60000000;
	localparam logic [31:0] XRAM_HI  = 32'h9FFFFFFF;
	localparam logic [31:0] XDEV_LO  = 32'hA0000000;
	localparam logic [31:0] XDEV_HI  = 32'hDFFFFFFF;
	localparam logic [31:0] PPB_LO   = 32'hE0000000;
	localparam logic [31:0] PPB_HI   = 32'hE00FFFFF;

	// outstanding transaction counter width
	localparam int OUTST_W = 4;
	// write buffer depth for device writes
	localparam int WBUF_DEPTH = 2;
	// reset values
	localparam logic [OUTST_W-1:0] OUTST_RST = 4'h0;
endpackage

// file: hdl/dmam_unit.sv
// dmam_unit: default address attribute decode, override merge, fetch fault,
// ordering gates and barrier sequencing for the core's memory path.
// assumes the core pulses issue/complete and barrier requests in clk_sys domain.
// assumes a request stays high until its grant shows, then drops or moves on;
// a request still high in the cycle its grant shows is not counted again.
// assumes barrier pulses that arrive outside run are simply ignored.
// Function
// - code region: normal, executable
// - sram region: normal, executable
// - peripheral region: device, execute never
// - external ram: normal, executable
// - external device: device, execute never
// - private bus strongly ordered, rest reserved
// - protection unit override replaces default attributes
// - prefetch ahead and at branch targets allowed
// - normal accesses may reorder or buffer
// - data barrier: drain before next access
// - sync barrier: drain before next instruction
// - instruction barrier flushes stale prefetch
// - protection change effective after sync barrier
// - software adds instruction barrier after branch
// - vector write visible after data barrier
// - modified code fetched after instruction barrier
// - memory map switch visible after sync
// - priority change done at sync completion
// - strongly ordered accesses kept in order
// - fault only when never-execute instruction executes
// - device/strong accesses observed in order
// - strongly ordered writes never buffered
`timescale 1ns/1ps
`default_nettype none
module dmam_unit #(
	parameter int OUTST_W = dmam_pkg::OUTST_W
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [31:0] fetch_addr,
	input  wire logic [31:0] data_addr,
	input  wire logic        ovr_en,
	input  wire logic [1:0]  ovr_type,
	input  wire logic        ovr_xn,
	input  wire logic        acc_req,
	input  wire logic        acc_write,
	input  wire logic        acc_done,
	input  wire logic        exec_valid,
	input  wire logic        exec_from_xn,
	input  wire logic        data_memory_barrier,
	input  wire logic        data_sync_barrier,
	input  wire logic        instruction_sync_barrier,
	output logic [1:0]       fetch_type,
	output logic             fetch_xn,
	output logic [1:0]       data_type,
	output logic             data_xn,
	output logic             acc_grant,
	output logic             acc_bufferable,
	output logic             exec_hold,
	output logic             prefetch_flush,
	output logic             xn_fault,
	output logic             barrier_done,
	output logic [OUTST_W-1:0] outstanding
);
	// refuse counter widths the grant and drain logic cannot serve
	if (OUTST_W < 2 || OUTST_W > 8) begin : g_bad_width
		$error("dmam_unit: OUTST_W out of range");
	end

	// barrier sequencer states; run is the only state that takes new work
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_DMB = 2'b01,
		ST_DSB = 2'b11,
		ST_ISB = 2'b10
	} dmam_state_type;

	// registered state and the combinational terms behind every output except xn_fault
	dmam_state_type     state;
	dmam_state_type     next_state;
	logic [2:0]         d_dec_c;
	logic [2:0]         f_dec_c;
	logic [1:0]         d_type_c;
	logic               d_xn_c;
	logic [1:0]         f_type_c;
	logic               f_xn_c;
	logic               run_c;
	logic               fresh_c;
	logic               ordered_c;
	logic               order_ok_c;
	logic               quiet_c;
	logic               full_c;
	logic               retire_c;
	logic               last_out_c;
	logic               grant_c;
	logic               drained_c;
	logic               ending_c;
	logic [OUTST_W-1:0] next_outstanding;

	// inclusive range test shared by the regions of the fixed map other than code
	function automatic logic dmam_in_range(
		input logic [31:0] a,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		return (a >= lo) && (a <= hi);
	endfunction

	// fixed region decode: {type, execute never}; gaps fall to reserved
	function automatic logic [2:0] dmam_decode(input logic [31:0] a);
		logic [2:0] r;
		r = {dmam_pkg::DMAM_RESERVED, 1'b1};
		if (a <= dmam_pkg::CODE_HI) begin
			r = {dmam_pkg::DMAM_NORMAL, 1'b0};
		end else if (dmam_in_range(a, dmam_pkg::SRAM_LO, dmam_pkg::SRAM_HI)) begin
			r = {dmam_pkg::DMAM_NORMAL, 1'b0};
		end else if (dmam_in_range(a, dmam_pkg::PERI_LO, dmam_pkg::PERI_HI)) begin
			r = {dmam_pkg::DMAM_DEVICE, 1'b1};
		end else if (dmam_in_range(a, dmam_pkg::XRAM_LO, dmam_pkg::XRAM_HI)) begin
			r = {dmam_pkg::DMAM_NORMAL, 1'b0};
		end else if (dmam_in_range(a, dmam_pkg::XDEV_LO, dmam_pkg::XDEV_HI)) begin
			r = {dmam_pkg::DMAM_DEVICE, 1'b1};
		end else if (dmam_in_range(a, dmam_pkg::PPB_LO, dmam_pkg::PPB_HI)) begin
			r = {dmam_pkg::DMAM_STRONG, 1'b1};
		end
		return r;
	endfunction

	// a type that keeps program order against other ordered accesses
	function automatic logic dmam_is_ordered(input logic [1:0] t);
		return t != dmam_pkg::DMAM_NORMAL;
	endfunction

	// a type whose writes may wait in a write buffer
	function automatic logic dmam_may_buffer(input logic [1:0] t);
		return t != dmam_pkg::DMAM_STRONG;
	endfunction

	// fixed map for both paths, looked up every cycle
	always_comb begin
		d_dec_c = dmam_decode(data_addr);
		f_dec_c = dmam_decode(fetch_addr);
	end

	// data path attributes; an active protection override replaces the map
	always_comb begin
		d_type_c = d_dec_c[2:1];
		d_xn_c   = d_dec_c[0];
		if (ovr_en) begin
			d_type_c = ovr_type;
			d_xn_c   = ovr_xn;
		end
	end

	// fetch path attributes; the same override applies to instruction fetch
	always_comb begin
		f_type_c = f_dec_c[2:1];
		f_xn_c   = f_dec_c[0];
		if (ovr_en) begin
			f_type_c = ovr_type;
			f_xn_c   = ovr_xn;
		end
	end

	// nothing in flight
	always_comb begin
		quiet_c = (outstanding == '0);
	end

	// counter full: another grant would wrap it
	always_comb begin
		full_c = (outstanding == '1);
	end

	// a completion only retires an access that is really outstanding
	always_comb begin
		retire_c = acc_done && !quiet_c;
	end

	// the last access in flight completes in this cycle
	always_comb begin
		last_out_c = (outstanding == OUTST_W'(1)) && acc_done;
	end

	// issue only from run, and only once per request
	always_comb begin
		run_c   = (state == ST_RUN);
		fresh_c = !acc_grant;
	end

	// ordered accesses wait for earlier ones to drain; normal ones may overlap
	always_comb begin
		ordered_c  = dmam_is_ordered(d_type_c);
		order_ok_c = !ordered_c || quiet_c || last_out_c;
		grant_c    = acc_req && run_c && fresh_c && !full_c && order_ok_c;
	end

	// next count: a grant and a retirement in one cycle cancel
	always_comb begin
		next_outstanding = outstanding;
		if (grant_c && !retire_c)
			next_outstanding = outstanding + 1'b1;
		else if (!grant_c && retire_c)
			next_outstanding = outstanding - 1'b1;
	end

	// all earlier accesses are gone once this edge has passed
	always_comb begin
		drained_c = (next_outstanding == '0);
	end

	// fetch type follows the fetch address, prefetch or not
	always_ff @(posedge clk_sys) begin
		if (srst)
			fetch_type <= 2'h0;
		else
			fetch_type <= f_type_c;
	end

	// fetch execute never; a prefetch from such space is no fault by itself
	always_ff @(posedge clk_sys) begin
		if (srst)
			fetch_xn <= 1'b0;
		else
			fetch_xn <= f_xn_c;
	end

	// data type of the access currently presented
	always_ff @(posedge clk_sys) begin
		if (srst)
			data_type <= 2'h0;
		else
			data_type <= d_type_c;
	end

	// data execute never of the access currently presented
	always_ff @(posedge clk_sys) begin
		if (srst)
			data_xn <= 1'b0;
		else
			data_xn <= d_xn_c;
	end

	// writes to strongly ordered space always go straight to the bus
	always_ff @(posedge clk_sys) begin
		if (srst)
			acc_bufferable <= 1'b0;
		else
			acc_bufferable <= acc_write && dmam_may_buffer(d_type_c);
	end

	// outstanding transaction count
	always_ff @(posedge clk_sys) begin
		if (srst)
			outstanding <= OUTST_W'(dmam_pkg::OUTST_RST);
		else
			outstanding <= next_outstanding;
	end

	// grant pulse: the access was counted at this edge
	always_ff @(posedge clk_sys) begin
		if (srst)
			acc_grant <= 1'b0;
		else
			acc_grant <= grant_c;
	end

	// barrier sequencer: sync beats data beats instruction when they collide
	always_comb begin
		next_state = state;
		unique case (state)
			// idle: take at most one barrier
			ST_RUN: begin
				if (data_sync_barrier)
					next_state = ST_DSB;
				else if (data_memory_barrier)
					next_state = ST_DMB;
				else if (instruction_sync_barrier)
					next_state = ST_ISB;
			end
			// later accesses are refused until the drain ends
			ST_DMB: begin
				if (drained_c)
					next_state = ST_RUN;
			end
			// later instructions are held until the drain ends
			ST_DSB: begin
				if (drained_c)
					next_state = ST_RUN;
			end
			// drain, then flush the prefetched words
			ST_ISB: begin
				if (drained_c)
					next_state = ST_RUN;
			end
		endcase
	end

	// a barrier finishes at the edge where the sequencer returns to run
	always_comb begin
		ending_c = (state != ST_RUN) && (next_state == ST_RUN);
	end

	// sequencer state register
	always_ff @(posedge clk_sys) begin
		if (srst)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	// one-cycle completion pulse; the count is already zero with it
	always_ff @(posedge clk_sys) begin
		if (srst)
			barrier_done <= 1'b0;
		else
			barrier_done <= ending_c;
	end

	// later instructions stall while a sync or instruction barrier drains
	always_ff @(posedge clk_sys) begin
		if (srst)
			exec_hold <= 1'b0;
		else
			exec_hold <= (next_state == ST_DSB) || (next_state == ST_ISB);
	end

	// stale prefetched words are dropped as an instruction barrier ends
	always_ff @(posedge clk_sys) begin
		if (srst)
			prefetch_flush <= 1'b0;
		else
			prefetch_flush <= ending_c && (state == ST_ISB);
	end

	// fault only on execution, never on prefetch
	always_ff @(posedge clk_sys) begin
		if (srst)
			xn_fault <= 1'b0;
		else
			xn_fault <= exec_valid && exec_from_xn;
	end
endmodule // dmam_unit
`default_nettype wire

// file: test/dmam_unit_chk.sv
// dmam_unit_chk: port assertions for dmam_unit
// bound below to every dmam_unit instance
`timescale 1ns/1ps
`default_nettype none
module dmam_unit_chk #(
	parameter int OUTST_W = 4
) (
	input wire logic               clk_sys,
	input wire logic               srst,
	input wire logic               ovr_en,
	input wire logic               ovr_xn,
	input wire logic               exec_valid,
	input wire logic               exec_from_xn,
	input wire logic               data_sync_barrier,
	input wire logic               instruction_sync_barrier,
	input wire logic               fetch_xn,
	input wire logic               data_xn,
	input wire logic               acc_grant,
	input wire logic               acc_bufferable,
	input wire logic               exec_hold,
	input wire logic               xn_fault,
	input wire logic               barrier_done,
	input wire logic [31:0]        fetch_addr,
	input wire logic [1:0]         ovr_type,
	input wire logic [1:0]         fetch_type,
	input wire logic [1:0]         data_type,
	input wire logic [OUTST_W-1:0] outstanding
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// a sync or instruction barrier that has nothing left to drain
	sequence s_drained;
		exec_hold && outstanding == 0;
	endsequence
	peri_map_a: assert property (
		!ovr_en && fetch_addr[31:29] == 3'h2 |=> fetch_xn && fetch_type == 2'h1) else $error("peri");
	ovr_fetch_a: assert property (
		ovr_en |=> fetch_type == $past(ovr_type) && fetch_xn == $past(ovr_xn)) else $error("ovr f");
	ovr_data_a: assert property (
		ovr_en |=> data_type == $past(ovr_type) && data_xn == $past(ovr_xn)) else $error("ovr d");
	xn_fault_a: assert property (
		1 |=> xn_fault == ($past(exec_valid) && $past(exec_from_xn))) else $error("fault");
	strong_nobuf_a: assert property (
		acc_bufferable |-> data_type != 2'h3) else $error("buffered");
	order_grant_a: assert property (
		acc_grant && data_type != 2'h0 |-> outstanding == 1) else $error("order");
	drain_done_a: assert property (
		barrier_done |-> outstanding == 0) else $error("drain");
	hold_release_a: assert property (
		s_drained |-> ##[0:2] barrier_done) else $error("release");
	hold_cause_a: assert property (
		$rose(exec_hold) |-> $past(data_sync_barrier) || $past(instruction_sync_barrier))
		else $error("hold");
endmodule // dmam_unit_chk
bind dmam_unit dmam_unit_chk #(.OUTST_W(OUTST_W)) dmam_unit_chk_inst (.*);
`default_nettype wire

// file: test/dmam_core_mdl.sv
// dmam_core_mdl: core side, completes granted accesses one at a time
// latency one cycle, or six while slow is high
`timescale 1ns/1ps
`default_nettype none
module dmam_core_mdl (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic acc_grant,
	input  wire logic slow,
	output logic      acc_done
);
	int   pend, tmr;
	logic fin;
	// oldest access has waited long enough
	always_comb fin = (pend > 0) && (tmr >= (slow ? 6 : 1));
	// count pending accesses, pulse one completion
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pend <= 0;
			tmr <= 0;
			acc_done <= 1'b0;
		end else begin
			pend <= pend + int'(acc_grant) - int'(fin);
			tmr <= (fin || pend == 0) ? 0 : tmr + 1;
			acc_done <= fin;
		end
	end
endmodule // dmam_core_mdl
`default_nettype wire

// file: test/tb.sv
// tb: self-checking bench for dmam_unit
// needs dmam_pkg, dmam_unit and the test files compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys, srst, ovr_en, ovr_xn, acc_req, acc_write, exec_valid, exec_from_xn, slow;
	logic data_memory_barrier, data_sync_barrier, instruction_sync_barrier, acc_done, dprev;
	logic fetch_xn, data_xn, acc_grant, acc_bufferable, exec_hold, prefetch_flush, xn_fault;
	logic barrier_done;
	logic [31:0] fetch_addr, data_addr, lfsr, a;
	logic [1:0] ovr_type, fetch_type, data_type;
	logic [3:0] outstanding;
	int miscompares, num_checks, cyc, n, eo;
	logic [31:0] tbl [14] = '{32'h0, 32'h1FFFFFFF, 32'h20000000, 32'h3FFFFFFF, 32'h40000000,
		32'h5FFFFFFF, 32'h60000000, 32'h9FFFFFFF, 32'hA0000000, 32'hDFFFFFFF, 32'hE0000000,
		32'hE00FFFFF, 32'hE0100000, 32'hFFFFFFFF};
	dmam_unit dmam_unit_inst (.*);
	dmam_core_mdl dmam_core_mdl_inst (.*);
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// expected {xn, type} of the fixed map
	function automatic logic [2:0] amap(logic [31:0] ad);
		if (ad < 32'h40000000 || (ad > 32'h5FFFFFFF && ad < 32'hA0000000)) return 3'h0;
		if (ad < 32'hE0000000) return 3'h5;
		return (ad < 32'hE0100000) ? 3'h7 : 3'h6;
	endfunction
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one data access, held until the grant is sampled
	task automatic acc(logic [31:0] ad);
		logic w;
		@(posedge clk_sys);
		w = lfsr[3];
		data_addr <= ad;
		acc_write <= w;
		acc_req <= 1'b1;
		lfsr = nxt(lfsr);
		n = 0;
		@(posedge clk_sys);
		while (acc_grant !== 1'b1 && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
		acc_req <= 1'b0;
		chk("grant", 1, n < 60);
		chk("bufferable", w && amap(ad) != 3'h7, acc_bufferable);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// outstanding count model, compared every cycle; also the run ceiling
	always @(negedge clk_sys) begin
		if (++cyc > 3000) begin
			miscompares++;
			end_sim;
		end
		eo = srst ? 0 : eo + acc_grant - dprev;
		dprev = srst ? 1'b0 : acc_done;
		if (!srst) chk("outstanding", eo, outstanding);
	end
	initial begin
		lfsr = 32'h3AD86A05;
		{srst, ovr_en, ovr_xn, acc_req, acc_write, exec_valid, exec_from_xn, slow} = 8'h81;
		{data_memory_barrier, data_sync_barrier, instruction_sync_barrier, ovr_type} = 5'h0;
		{fetch_addr, data_addr} = 64'h0; // fetch starts in the code region
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		// region bounds then random addresses, override at the end
		for (int i = 0; i < 30; i++) begin
			a = (i < 14) ? tbl[i] : lfsr;
			ovr_en <= (i > 21);
			{ovr_xn, ovr_type} <= lfsr[6:4];
			fetch_addr <= a;
			data_addr <= ~a;
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk("fetch", ovr_en ? {ovr_xn, ovr_type} : amap(a), {fetch_xn, fetch_type});
			chk("data", ovr_en ? {ovr_xn, ovr_type} : amap(~a), {data_xn, data_type});
			lfsr = nxt(lfsr);
			@(posedge clk_sys);
		end
		ovr_en <= 1'b0;
		// fault only on an execute-never instruction
		for (int k = 0; k < 2; k++) begin
			exec_valid <= 1'b1;
			exec_from_xn <= k[0];
			@(posedge clk_sys);
			exec_valid <= 1'b0;
			@(negedge clk_sys);
			chk("xn_fault", k, xn_fault);
			@(posedge clk_sys);
		end
		// two ordered accesses: second waits for the first
		acc(32'hE0000000);
		acc(32'hE0000004);
		chk("ordered", 1, outstanding);
		// each barrier kind with accesses still in flight
		for (int b = 0; b < 3; b++) begin
			slow <= (b != 1);
			acc(32'h40000000);
			acc(32'h60000000);
			data_memory_barrier <= (b == 0);
			data_sync_barrier <= (b == 1);
			instruction_sync_barrier <= (b == 2);
			@(posedge clk_sys);
			{data_memory_barrier, data_sync_barrier, instruction_sync_barrier} <= 3'h0;
			@(negedge clk_sys);
			chk("exec_hold", b != 0, exec_hold);
			n = 0;
			while (barrier_done !== 1'b1 && n < 40) begin
				@(negedge clk_sys);
				n++;
			end
			chk("barrier_done", 1, barrier_done);
			if (b < 2) chk("drained", 0, outstanding);
			else chk("prefetch_flush", 1, prefetch_flush);
		end
		end_sim;
	end
endmodule // tb
`default_nettype wire
